/* design/ep0rx_ctrl.v */
// Purpose : Endpoint 0 receive control: byte count, control bits,
//           handshake choice, receive FIFO and its flags
// Assumes : Packet engine gives byte strobes and one end pulse per
//           transaction; all inputs synchronous to ref_clk
// Notes   : Handshake is decided combinationally from the control
//           register so the engine may sample it at packet end
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "ep0rx_map.vh"

module ep0rx_ctrl (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Packet engine side
  input  wire       pkt_start,
  input  wire       pkt_is_setup,
  input  wire       pkt_byte_vld,
  input  wire [7:0] pkt_byte,
  input  wire       pkt_end,
  input  wire       pkt_ok,
  output wire [1:0] pkt_handshake,
  output wire       pkt_accept,
  // Link status
  input  wire       tx_endpoint_enable,
  output wire       port_connect,
  // FIFO read by the microcontroller
  input  wire       fifo_rd,
  output reg  [7:0] fifo_rdata,
  // Interrupt
  output wire       irq
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  reg [`EP0RX_CNT_W-1:0] rx_byte_count_q;
  reg                    rx_fifo_clear_q;
  reg                    rx_stall_request_q;
  reg                    rx_fifo_accept_q;
  reg                    rx_endpoint_enable_q;
  reg [7:0]              stat_q;
  reg [3:0]              flags_q;
  reg [1:0]              irq_stat_q;
  reg [1:0]              irq_mask_q;
  reg [7:0]              mem [0:`EP0RX_FIFO_DEPTH-1];
  reg [`EP0RX_PTR_W-1:0] wptr_q;
  reg [`EP0RX_PTR_W-1:0] rptr_q;
  reg [`EP0RX_PTR_W:0]   fill_q;
  reg [`EP0RX_CNT_W-1:0] pkt_cnt_q;
  reg                    in_setup_q;

  wire wr_ctrl  = reg_wr && (reg_addr == `EP0RX_ADDR_CTRL);
  wire wr_stat  = reg_wr && (reg_addr == `EP0RX_ADDR_STAT);
  wire wr_irq   = reg_wr && (reg_addr == `EP0RX_ADDR_IRQ);
  wire wr_mask  = reg_wr && (reg_addr == `EP0RX_ADDR_MASK);
  wire fifo_empty = (fill_q == {(`EP0RX_PTR_W+1){1'b0}});
  wire fifo_full  = (fill_q == `EP0RX_FIFO_DEPTH);

  // --------------------------------------------------------------
  // Handshake selection
  // --------------------------------------------------------------
  // Setup always taken when good; OUT depends on stall, accept and enable bits
  assign pkt_accept = pkt_is_setup ? 1'b1
                    : (rx_fifo_accept_q && !rx_stall_request_q &&
                       rx_endpoint_enable_q);
  assign pkt_handshake = pkt_is_setup ? `EP0RX_HS_ACK
                       : rx_stall_request_q ? `EP0RX_HS_STALL
                       : !pkt_accept ? `EP0RX_HS_NACK
                       : `EP0RX_HS_ACK;
  // Both endpoint halves must be on before the pull-up is presented
  assign port_connect = rx_endpoint_enable_q && tx_endpoint_enable;

  wire setup_good = pkt_end && pkt_ok && pkt_is_setup;
  wire out_valid  = pkt_end && pkt_ok && !pkt_is_setup;
  wire out_acked  = out_valid && pkt_accept;
  wire wr_byte    = pkt_byte_vld && (in_setup_q || pkt_accept) && !rx_fifo_clear_q;
  wire rd_byte    = fifo_rd && !rx_fifo_clear_q;
  wire overrun    = wr_byte && fifo_full;
  wire underrun   = rd_byte && fifo_empty;
  wire do_push    = wr_byte && !fifo_full;
  wire do_pop     = rd_byte && !fifo_empty;

  // --------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------
  // Hardware clears come after the software write so they win
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_fifo_clear_q      <= 1'b0;
      rx_stall_request_q   <= 1'b0;
      rx_fifo_accept_q     <= 1'b0;
      rx_endpoint_enable_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        rx_fifo_clear_q      <= reg_wdata[`EP0RX_CTL_CLR];
        rx_stall_request_q   <= reg_wdata[`EP0RX_CTL_STL];
        rx_fifo_accept_q     <= reg_wdata[`EP0RX_CTL_FEN];
        rx_endpoint_enable_q <= reg_wdata[`EP0RX_CTL_EN];
      end
      if (rx_fifo_clear_q)
        rx_fifo_clear_q <= 1'b0;
      if (setup_good)
        rx_stall_request_q <= 1'b0;
      if (out_acked || setup_good || rx_fifo_clear_q)
        rx_fifo_accept_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Byte counting and receive status
  // --------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_byte_count_q <= {`EP0RX_CNT_W{1'b0}};
      pkt_cnt_q       <= {`EP0RX_CNT_W{1'b0}};
      in_setup_q      <= 1'b0;
      stat_q          <= 8'h00;
    end else begin
      if (pkt_start) begin
        pkt_cnt_q  <= {`EP0RX_CNT_W{1'b0}};
        in_setup_q <= pkt_is_setup;
      end else if (wr_byte) begin
        pkt_cnt_q <= pkt_cnt_q + 4'h1;
      end
      // Reading the FIFO never touches the count
      if (setup_good || out_acked)
        rx_byte_count_q <= pkt_cnt_q;
      if (wr_stat && reg_wdata[`EP0RX_ST_SETUP])
        stat_q[`EP0RX_ST_SETUP] <= 1'b0;
      if (wr_stat && reg_wdata[`EP0RX_ST_ACK])
        stat_q[`EP0RX_ST_ACK] <= 1'b0;
      if (setup_good) begin
        stat_q[`EP0RX_ST_SETUP] <= 1'b1;
        stat_q[`EP0RX_ST_ACK]   <= 1'b0;
      end
      if (pkt_end && !pkt_is_setup) begin
        stat_q[`EP0RX_ST_ERROR] <= !pkt_ok;
        stat_q[`EP0RX_ST_STALL] <= out_valid && rx_stall_request_q;
        stat_q[`EP0RX_ST_NACK]  <= out_valid && !rx_stall_request_q && !pkt_accept;
        if (out_acked)
          stat_q[`EP0RX_ST_ACK] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Receive FIFO
  // --------------------------------------------------------------
  // Software is expected to clear on over/under-run; the flags stay up
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wptr_q     <= {`EP0RX_PTR_W{1'b0}};
      rptr_q     <= {`EP0RX_PTR_W{1'b0}};
      fill_q     <= {(`EP0RX_PTR_W+1){1'b0}};
      flags_q    <= `EP0RX_FL_RESET;
      fifo_rdata <= 8'h00;
    end else if (rx_fifo_clear_q) begin
      wptr_q  <= {`EP0RX_PTR_W{1'b0}};
      rptr_q  <= {`EP0RX_PTR_W{1'b0}};
      fill_q  <= {(`EP0RX_PTR_W+1){1'b0}};
      flags_q <= `EP0RX_FL_RESET;
    end else begin
      if (do_push) begin
        mem[wptr_q] <= pkt_byte;
        wptr_q      <= wptr_q + 3'h1;
      end
      if (do_pop) begin
        fifo_rdata <= mem[rptr_q];
        rptr_q     <= rptr_q + 3'h1;
      end
      if (do_push && !do_pop)
        fill_q <= fill_q + 4'h1;
      else if (do_pop && !do_push)
        fill_q <= fill_q - 4'h1;
      flags_q[`EP0RX_FL_EMPTY] <= (fill_q == 4'h0 && !do_push) ||
                                  (fill_q == 4'h1 && do_pop && !do_push);
      flags_q[`EP0RX_FL_FULL]  <= (fill_q == 4'h8 && !do_pop) ||
                                  (fill_q == 4'h7 && do_push && !do_pop);
      if (underrun)
        flags_q[`EP0RX_FL_UNDR] <= 1'b1;
      if (overrun)
        flags_q[`EP0RX_FL_OVRR] <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------
  // Write-one-to-clear; a new event in the same cycle wins
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr_mask)
        irq_mask_q <= reg_wdata[1:0];
      irq_stat_q[`EP0RX_IRQ_RX] <= (irq_stat_q[`EP0RX_IRQ_RX] &&
          !(wr_irq && reg_wdata[`EP0RX_IRQ_RX])) || out_acked;
      irq_stat_q[`EP0RX_IRQ_FIFO] <= (irq_stat_q[`EP0RX_IRQ_FIFO] &&
          !(wr_irq && reg_wdata[`EP0RX_IRQ_FIFO])) || overrun || underrun;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // --------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------
  // Data in the cycle after the strobe; unmapped reads give zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `EP0RX_ADDR_COUNT: reg_rdata <= {4'h0, rx_byte_count_q};
        `EP0RX_ADDR_CTRL:  reg_rdata <= {rx_fifo_clear_q, 3'h0, rx_stall_request_q,
                                         1'b0, rx_fifo_accept_q,
                                         rx_endpoint_enable_q};
        `EP0RX_ADDR_STAT:  reg_rdata <= stat_q;
        `EP0RX_ADDR_FLAGS: reg_rdata <= {4'h0, flags_q};
        `EP0RX_ADDR_IRQ:   reg_rdata <= {6'h00, irq_stat_q};
        `EP0RX_ADDR_MASK:  reg_rdata <= {6'h00, irq_mask_q};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // ep0rx_ctrl

/* design/ep0rx_map.vh */
// Purpose : Constants for the endpoint 0 receive control block
// Assumes : 8-bit register port, one clock (ref_clk, 50 MHz)
// Notes   : Notes on behaviour follow below
`ifndef EP0RX_MAP_VH
`define EP0RX_MAP_VH

// --------------------------------------------------------------
// Register addresses
// --------------------------------------------------------------
`define EP0RX_ADDR_COUNT  4'h0
`define EP0RX_ADDR_CTRL   4'h1
`define EP0RX_ADDR_STAT   4'h2
`define EP0RX_ADDR_FLAGS  4'h3
`define EP0RX_ADDR_IRQ    4'h4
`define EP0RX_ADDR_MASK   4'h5

// --------------------------------------------------------------
// Control register fields
// --------------------------------------------------------------
`define EP0RX_CTL_CLR     7
`define EP0RX_CTL_STL     3
`define EP0RX_CTL_FEN     1
`define EP0RX_CTL_EN      0
`define EP0RX_CTL_WMASK   8'h8b

// --------------------------------------------------------------
// Status, flag and interrupt fields
// --------------------------------------------------------------
`define EP0RX_ST_SETUP    6
`define EP0RX_ST_STALL    3
`define EP0RX_ST_NACK     2
`define EP0RX_ST_ERROR    1
`define EP0RX_ST_ACK      0
`define EP0RX_FL_EMPTY    3
`define EP0RX_FL_FULL     2
`define EP0RX_FL_UNDR     1
`define EP0RX_FL_OVRR     0
`define EP0RX_FL_RESET    4'h8
`define EP0RX_IRQ_RX      0
`define EP0RX_IRQ_FIFO    1

// --------------------------------------------------------------
// Handshake codes and FIFO geometry
// --------------------------------------------------------------
`define EP0RX_HS_ACK      2'h0
`define EP0RX_HS_NACK     2'h1
`define EP0RX_HS_STALL    2'h2
`define EP0RX_HS_NONE     2'h3
`define EP0RX_FIFO_DEPTH  8
`define EP0RX_PTR_W       3
`define EP0RX_CNT_W       4

`endif

/* testbench/ep0rx_ctrl_properties.sv */
// Purpose : Port-level checks for the endpoint 0 receive control block
// Assumes : Single clock domain, rst asynchronous and active high
// Notes   : Handshake codes 0 ACK, 1 NACK, 2 STALL
`timescale 1ns/1ps
module ep0rx_ctrl_chk (
  // Clock, reset and register port
  input wire       ref_clk,
  input wire       rst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Packet side and link
  input wire       pkt_is_setup,
  input wire       pkt_end,
  input wire       pkt_ok,
  input wire [1:0] pkt_handshake,
  input wire       pkt_accept,
  input wire       tx_endpoint_enable,
  input wire       port_connect
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Sticky bits must not leak into reserved positions
  cnt_resv_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata[7:4] == 4'h0)
    else $error("byte count reserved bits not zero");
  ctl_resv_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1 |-> (reg_rdata & 8'h74) == 8'h00)
    else $error("control reserved bits not zero");
  link_conn_a: assert property (!tx_endpoint_enable |-> !port_connect)
    else $error("port connected without transmit enable");
  setup_take_a: assert property (pkt_is_setup |-> pkt_accept)
    else $error("setup data refused");
  setup_ack_a: assert property (pkt_end && pkt_ok && pkt_is_setup |-> pkt_handshake == 2'h0)
    else $error("good setup not acknowledged");
  out_ack_a: assert property (!pkt_is_setup && pkt_handshake == 2'h0 |-> pkt_accept)
    else $error("out acknowledged while not accepting");
  stall_wins_a: assert property (pkt_handshake == 2'h2 |-> !pkt_accept)
    else $error("stall given while accepting");
  ack_drop_a: assert property (pkt_end && pkt_ok && !pkt_is_setup && pkt_handshake == 2'h0
    |=> !pkt_accept || pkt_is_setup)
    else $error("accept bit survives acknowledged out");
  setup_clr_a: assert property (pkt_end && pkt_ok && pkt_is_setup
    |=> pkt_is_setup || pkt_handshake == 2'h1)
    else $error("stall or accept survives good setup");
  wipe_fen_a: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata[7]
    |-> ##2 (!pkt_accept || pkt_is_setup))
    else $error("accept bit survives fifo clear");
endmodule // ep0rx_ctrl_chk

bind ep0rx_ctrl ep0rx_ctrl_chk ep0rx_ctrl_chk_inst (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pkt_is_setup(pkt_is_setup), .pkt_end(pkt_end), .pkt_ok(pkt_ok),
  .pkt_handshake(pkt_handshake), .pkt_accept(pkt_accept),
  .tx_endpoint_enable(tx_endpoint_enable), .port_connect(port_connect));

/* testbench/ep0rx_host.sv */
// Purpose : Behavioural upstream host sending Setup and OUT packets
// Assumes : Packet fields change just after a rising edge
// Notes   : Idle data shows the inverse of the last byte, never a held value
`timescale 1ns/1ps
module ep0rx_host (
  // Clock and link state
  input  wire        ref_clk,
  input  wire        port_connect,
  // Packet engine outputs
  output logic       pkt_start,
  output logic       pkt_is_setup,
  output logic       pkt_byte_vld,
  output logic [7:0] pkt_byte,
  output logic       pkt_end,
  output logic       pkt_ok
);
  initial {pkt_start, pkt_is_setup, pkt_byte_vld, pkt_byte, pkt_end, pkt_ok} = '0;
  // One transaction: token, n data bytes, end with validity
  task automatic xfer(input logic setup, input int n, input logic ok);
    int i;
    i = 0;
    while (!port_connect && i < 100) begin
      @(posedge ref_clk);
      i++;
    end
    @(posedge ref_clk);
    pkt_start    <= 1'b1;
    pkt_is_setup <= setup;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      pkt_start    <= 1'b0;
      pkt_byte_vld <= 1'b1;
      pkt_byte     <= 8'($urandom);
    end
    @(posedge ref_clk);
    pkt_start    <= 1'b0;
    pkt_byte_vld <= 1'b0;
    pkt_byte     <= ~pkt_byte;
    pkt_end      <= 1'b1;
    pkt_ok       <= ok;
    @(posedge ref_clk);
    pkt_end      <= 1'b0;
    pkt_ok       <= 1'b0;
    pkt_is_setup <= 1'b0;
  endtask
endmodule // ep0rx_host

/* testbench/ep0rx_ctrl_tb.sv */
// Purpose : Self-checking bench for the endpoint 0 receive control block
// Assumes : 50 MHz clock, reset held 8 cycles
// Notes   : Expected reads and handshakes are queued and popped by monitors
`timescale 1ns/1ps
module ep0rx_ctrl_tb;
  logic       ref_clk, rst, reg_wr, reg_rd, fifo_rd, tx_endpoint_enable, rd_d;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, fifo_rdata;
  logic       pkt_start, pkt_is_setup, pkt_byte_vld, pkt_end, pkt_ok, pkt_accept;
  logic       port_connect, irq;
  logic [7:0] pkt_byte;
  logic [1:0] pkt_handshake;
  logic [7:0] rq[$], hq[$];
  int         failures, total_checks, n;
  ep0rx_ctrl ep0rx_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pkt_start(pkt_start), .pkt_is_setup(pkt_is_setup), .pkt_byte_vld(pkt_byte_vld),
    .pkt_byte(pkt_byte), .pkt_end(pkt_end), .pkt_ok(pkt_ok), .pkt_handshake(pkt_handshake),
    .pkt_accept(pkt_accept), .tx_endpoint_enable(tx_endpoint_enable),
    .port_connect(port_connect), .fifo_rd(fifo_rd), .fifo_rdata(fifo_rdata), .irq(irq));
  ep0rx_host ep0rx_host_inst (.ref_clk(ref_clk), .port_connect(port_connect),
    .pkt_start(pkt_start), .pkt_is_setup(pkt_is_setup), .pkt_byte_vld(pkt_byte_vld),
    .pkt_byte(pkt_byte), .pkt_end(pkt_end), .pkt_ok(pkt_ok));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask
  task automatic pkt(input logic s, input int k, input logic [7:0] hs);
    hq.push_back(hs);
    ep0rx_host_inst.xfer(s, k, 1'b1);
  endtask
  task automatic close_out;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe; handshake at packet end
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_d) chk(reg_rdata, rq.pop_front());
    if (pkt_end) chk({6'h00, pkt_handshake}, hq.pop_front());
  end
  initial begin
    #1000000;
    failures++;
    close_out();
  end
  initial begin
    {rst, reg_wr, reg_rd, fifo_rd, tx_endpoint_enable, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    void'($urandom(93323));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h08);
    rd(4'h9, 8'h00);
    wr(4'h1, 8'h01);
    @(negedge ref_clk) chk({7'h00, port_connect}, 8'h00);
    @(posedge ref_clk) tx_endpoint_enable <= 1'b1;
    @(negedge ref_clk) chk({7'h00, port_connect}, 8'h01);
    $display("test reset done");
    pkt(1'b0, 2, 8'h01);
    wr(4'h1, 8'h09);
    pkt(1'b0, 2, 8'h02);
    n = 1 + $urandom % 8;
    pkt(1'b1, n, 8'h00);
    rd(4'h0, 8'(n));
    rd(4'h1, 8'h01);
    $display("test handshake done");
    wr(4'h1, 8'h7b);
    rd(4'h1, 8'h0b);
    wr(4'h1, 8'h83);
    repeat (2) @(posedge ref_clk);
    rd(4'h1, 8'h01);
    rd(4'h3, 8'h08);
    @(posedge ref_clk) fifo_rd <= 1'b1;
    @(posedge ref_clk) fifo_rd <= 1'b0;
    rd(4'h3, 8'h0a);
    wr(4'h1, 8'h81);
    repeat (2) @(posedge ref_clk);
    rd(4'h3, 8'h08);
    $display("test clear done");
    wr(4'h5, 8'h01);
    wr(4'h1, 8'h03);
    n = 2 + $urandom % 7;
    pkt(1'b0, n, 8'h00);
    @(negedge ref_clk) chk({7'h00, irq}, 8'h01);
    rd(4'h1, 8'h01);
    rd(4'h2, 8'h41);
    @(posedge ref_clk) fifo_rd <= 1'b1;
    repeat (2) @(posedge ref_clk);
    fifo_rd <= 1'b0;
    rd(4'h0, 8'(n));
    wr(4'h4, 8'h01);
    @(negedge ref_clk) chk({7'h00, irq}, 8'h00);
    pkt(1'b0, 1, 8'h01);
    repeat (2) @(posedge ref_clk);
    $display("test receive done");
    close_out();
  end
endmodule // ep0rx_ctrl_tb
